// ===== verification/tb_reader_mode_rate_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_reader_mode_rate_control;
   import rmrc_pkg::*;
   localparam logic [7:0] NRATE = 8'h12;
   logic             ref_clk_i;
   logic             arst_n_i;
   logic             psel_i;
   logic             penable_i;
   logic             pwrite_i;
   logic [7:0]       paddr_i;
   logic [31:0]      pwdata_i;
   logic [3:0]       pstrb_i;
   logic [31:0]      prdata_o;
   logic             pready_o;
   logic             pslverr_o;
   logic             channel_choice_i;
   logic             ext_field_off_i;
   logic             peer_mode_tx_done_i;
   rmrc_ctrl_t       ctrl_o;
   logic             collision_resp_start_o;
   logic [31:0]      rd;
   logic             er;
   logic             seen;
   int               n_errors;
   int               num_checks;
   int               cycles;
   // Rows: address, write data, expected read, expected error, strobe
   localparam logic [7:0] ROWS [6][5] = '{'{8'h08, 8'hFF, 8'hFC, 8'h00, 8'hF},
      '{8'h0C, 8'hFF, 8'hF9, 8'h00, 8'hF}, '{8'h10, 8'hA5, 8'hA5, 8'h00, 8'hF},
      '{8'h10, 8'h33, 8'hA5, 8'h00, 8'h0}, '{8'h1C, 8'h5A, 8'h00, 8'h01, 8'hF},
      '{8'h14, 8'h00, 8'h00, 8'h00, 8'hF}};
   // Rows: mode, rate, expected transmit allowed
   localparam logic [7:0] MT [11][3] = '{'{8'h90, 8'h00, 8'h0}, '{8'h88, 8'h00, 8'h1},
      '{8'h08, 8'h40, 8'h0}, '{8'h10, 8'h44, 8'h1}, '{8'h10, 8'h46, 8'h0},
      '{8'h10, 8'h70, 8'h0}, '{8'h00, 8'h00, 8'h1}, '{8'h20, 8'h00, 8'h1},
      '{8'h28, 8'h00, 8'h0}, '{8'h70, 8'h00, 8'h1}, '{8'h78, 8'h00, 8'h1}};

   rmrc_top #(.NORMAL_NFC_RATE(NRATE)) dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .channel_choice_i(channel_choice_i),
      .ext_field_off_i(ext_field_off_i), .peer_mode_tx_done_i(peer_mode_tx_done_i),
      .ctrl_o(ctrl_o), .collision_resp_start_o(collision_resp_start_o));

   // Clock at 40 MHz
   initial
   begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hF);
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h00_0000, d};
      pstrb_i <= s;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h00_0000, exp});
   endtask

   task automatic test_done();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cycle limit against hangs
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles >= 5000)
      begin
         n_errors++;
         test_done();
      end
   end

   initial
   begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
      {channel_choice_i, ext_field_off_i, peer_mode_tx_done_i} = '0;
      {n_errors, num_checks, cycles} = '0;
      arst_n_i = 1'b0;
      cyc(16);
      arst_n_i <= 1'b1;
      rchk(OFF_OPERATION_CONTROL, RST_OPERATION_CONTROL);
      rchk(OFF_MODE_DEFINITION, RST_MODE_DEFINITION);
      rchk(OFF_BIT_RATE_DEFINITION, RST_BIT_RATE_DEFINITION);
      // Write then read back each row
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, ROWS[i][0], ROWS[i][1], ROWS[i][4][3:0]);
         rchk(ROWS[i][0], ROWS[i][2]);
         chk({31'h0, er}, {31'h0, ROWS[i][3][0]});
      end
      // Set-default keeps operation control, restores mode and rate
      apb(1'b1, OFF_COMMAND_EVENTS, 8'h01);
      rchk(OFF_OPERATION_CONTROL, 8'hFC);
      rchk(OFF_MODE_DEFINITION, 8'h08);
      rchk(OFF_BIT_RATE_DEFINITION, 8'h00);
      channel_choice_i <= 1'b1;
      cyc(3);
      chk({ctrl_o.osc_reg_on, ctrl_o.rx_allowed, ctrl_o.tx_allowed}, 3'b111);
      chk({ctrl_o.am_channel_on, ctrl_o.pm_channel_on, ctrl_o.wakeup_mode_on}, 3'b011);
      // Both channels, automatic choice, receive off
      apb(1'b1, OFF_OPERATION_CONTROL, 8'h88);
      cyc(2);
      chk({ctrl_o.rx_allowed, ctrl_o.am_channel_on, ctrl_o.pm_channel_on}, 3'b011);
      chk({ctrl_o.auto_channel, ctrl_o.wakeup_mode_on}, 2'b10);
      apb(1'b1, OFF_OPERATION_CONTROL, 8'hD8);
      // Role, mode and rate combinations against transmit permission
      for (int i = 0; i < 11; i++)
      begin
         apb(1'b1, OFF_MODE_DEFINITION, MT[i][0]);
         apb(1'b1, OFF_BIT_RATE_DEFINITION, MT[i][1]);
         cyc(2);
         chk({ctrl_o.tx_allowed, ctrl_o.rx_allowed}, {2{MT[i][2][0]}});
         chk({ctrl_o.target_role, ctrl_o.operation_mode_code}, MT[i][0][7:3]);
      end
      // Field-on sets transmit, peer transmit done clears it
      apb(1'b1, OFF_OPERATION_CONTROL, 8'h80);
      apb(1'b1, OFF_COMMAND_EVENTS, 8'h02);
      rchk(OFF_OPERATION_CONTROL, 8'h88);
      apb(1'b1, OFF_MODE_DEFINITION, 8'h00);
      @(posedge ref_clk_i) peer_mode_tx_done_i <= 1'b1;
      @(posedge ref_clk_i) peer_mode_tx_done_i <= 1'b0;
      rchk(OFF_OPERATION_CONTROL, 8'h80);
      // Normal mode command loads the rate register
      apb(1'b1, OFF_COMMAND_EVENTS, 8'h04);
      rchk(OFF_BIT_RATE_DEFINITION, NRATE);
      chk({ctrl_o.transmit_rate_code, ctrl_o.receive_rate_code}, NRATE);
      // Field off starts collision avoidance only when enabled
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, OFF_MODE_DEFINITION, 8'(m));
         seen = 1'b0;
         @(posedge ref_clk_i) ext_field_off_i <= 1'b1;
         repeat (5) @(posedge ref_clk_i) seen |= (collision_resp_start_o === 1'b1);
         chk({31'h0, seen}, m);
         ext_field_off_i <= 1'b0;
      end
      // Mid-run power-up reset clears operation control again
      arst_n_i <= 1'b0;
      cyc(2);
      arst_n_i <= 1'b1;
      rchk(OFF_OPERATION_CONTROL, RST_OPERATION_CONTROL);
      rchk(OFF_BIT_RATE_DEFINITION, RST_BIT_RATE_DEFINITION);
      test_done();
   end
endmodule
`default_nettype wire

// ===== verilog/rmrc_pkg.sv
package rmrc_pkg;

   // Register byte addresses
   localparam logic [7:0] OFF_OPERATION_CONTROL   = 8'h08;
   localparam logic [7:0] OFF_MODE_DEFINITION     = 8'h0C;
   localparam logic [7:0] OFF_BIT_RATE_DEFINITION = 8'h10;
   localparam logic [7:0] OFF_COMMAND_EVENTS      = 8'h14;
   localparam logic [7:0] OFF_STATUS              = 8'h18;

   // Register indices as printed
   localparam int IDX_OPERATION_CONTROL   = 2;
   localparam int IDX_MODE_DEFINITION     = 3;
   localparam int IDX_BIT_RATE_DEFINITION = 4;

   // Reset values
   localparam logic [7:0] RST_OPERATION_CONTROL   = 8'h00;
   localparam logic [7:0] RST_MODE_DEFINITION     = 8'h08;
   localparam logic [7:0] RST_BIT_RATE_DEFINITION = 8'h00;

   // Writable bit masks
   localparam logic [7:0] MASK_OPERATION_CONTROL = 8'hFC;
   localparam logic [7:0] MASK_MODE_DEFINITION   = 8'hF9;

   // Operation control field positions
   localparam int OC_READY       = 7;
   localparam int OC_RX_ENABLE   = 6;
   localparam int OC_ONE_CHANNEL = 5;
   localparam int OC_MANUAL_SEL  = 4;
   localparam int OC_TX_ENABLE   = 3;
   localparam int OC_WAKEUP      = 2;

   // Mode definition field positions
   localparam int MD_TARGET      = 7;
   localparam int MD_OM_HI       = 6;
   localparam int MD_OM_LO       = 3;
   localparam int MD_AUTO_RESP   = 0;

   // Command event register bit positions
   localparam int CE_SET_DEFAULT = 0;
   localparam int CE_FIELD_ON    = 1;
   localparam int CE_NORMAL_NFC  = 2;
   localparam int CE_TX_DONE     = 3;

   // Initiator operation modes
   localparam logic [3:0] OM_I_ACTIVE_PEER = 4'h0;
   localparam logic [3:0] OM_I_TYPE_A      = 4'h1;
   localparam logic [3:0] OM_I_TYPE_B      = 4'h2;
   localparam logic [3:0] OM_I_PROP_CARD   = 4'h3;
   localparam logic [3:0] OM_I_TYPE1_TAG   = 4'h4;
   localparam logic [3:0] OM_I_SUBC_STREAM = 4'hE;
   localparam logic [3:0] OM_I_BPSK_STREAM = 4'hF;
   // Target operation modes
   localparam logic [3:0] OM_T_ACTIVE_DET  = 4'h0;
   localparam logic [3:0] OM_T_ACTIVE_NORM = 4'h1;

   // Bit rate codes
   localparam logic [3:0] RATE_FC128 = 4'h0;
   localparam logic [3:0] RATE_FC8   = 4'h4;
   localparam logic [3:0] RATE_FC4   = 4'h5;
   localparam logic [3:0] RATE_FC2   = 4'h6;

   // Decoded control towards the front end
   typedef struct packed {
      logic       osc_reg_on;
      logic       rx_allowed;
      logic       tx_allowed;
      logic       am_channel_on;
      logic       pm_channel_on;
      logic       auto_channel;
      logic       wakeup_mode_on;
      logic       target_role;
      logic [3:0] operation_mode_code;
      logic [3:0] transmit_rate_code;
      logic [3:0] receive_rate_code;
   } rmrc_ctrl_t;

endpackage

// ===== verilog/rmrc_top.sv
// Function
// - Ready bit powers oscillator and regulator
// - Receive enable bit gates all reception
// - One-channel bit picks channel by choice bit
// - Manual select bit turns off automatic channel choice
// - Transmit bit set by field-on, cleared after transmission in peer modes only
// - Wake-up bit enters wake-up mode
// - Operation control resets only at power-up
// - Role bit selects interpretation of mode
// - Mode and rate reset on set-default too
// - Initiator mode code map
// - Target mode code map
// - Unsupported mode disables transmit and receive
// - Auto response collision avoidance on field off
// - Transmit rate code fc/128 to fc/2
// - Receive rate code, same encoding
// - Very high transmit rates limited by mode, receive rates by code
// - Unsupported rate disables transmit and receive
// - Normal NFC command loads bit rate register
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

module rmrc_top
   import rmrc_pkg::*;
#(
   parameter logic [7:0] NORMAL_NFC_RATE = 8'h00
)(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Front end events
   input  wire logic        channel_choice_i,
   input  wire logic        ext_field_off_i,
   input  wire logic        peer_mode_tx_done_i,
   // Front end control
   output rmrc_ctrl_t       ctrl_o,
   output logic             collision_resp_start_o
);

   logic [7:0] operation_control;
   logic [7:0] mode_definition;
   logic [7:0] bit_rate_definition;
   logic       field_seen_off;

   // Bus decode
   wire logic setup     = psel_i & ~penable_i;
   wire logic access    = psel_i & penable_i & pready_o;
   wire logic wr        = access & pwrite_i & pstrb_i[0];
   wire logic hit_oc    = paddr_i == OFF_OPERATION_CONTROL;
   wire logic hit_md    = paddr_i == OFF_MODE_DEFINITION;
   wire logic hit_br    = paddr_i == OFF_BIT_RATE_DEFINITION;
   wire logic hit_ce    = paddr_i == OFF_COMMAND_EVENTS;
   wire logic hit_st    = paddr_i == OFF_STATUS;
   wire logic mapped    = hit_oc | hit_md | hit_br | hit_ce | hit_st;
   wire logic [7:0] wd  = pwdata_i[7:0];

   // Command pulses written by software to the event register; transmit done also comes from the peer input
   wire logic cmd_set_default = wr & hit_ce & wd[CE_SET_DEFAULT];
   wire logic cmd_field_on    = wr & hit_ce & wd[CE_FIELD_ON];
   wire logic cmd_normal_nfc  = wr & hit_ce & wd[CE_NORMAL_NFC];
   wire logic tx_done_evt     = peer_mode_tx_done_i | (wr & hit_ce & wd[CE_TX_DONE]);

   // Fields
   wire logic       targ      = mode_definition[MD_TARGET];
   wire logic [3:0] om        = mode_definition[MD_OM_HI:MD_OM_LO];
   wire logic [3:0] tx_rate   = bit_rate_definition[7:4];
   wire logic [3:0] rx_rate   = bit_rate_definition[3:0];

   // Mode validity per role
   function automatic logic mode_ok(input logic t, input logic [3:0] code);
      if (t)
      begin
         mode_ok = (code == OM_T_ACTIVE_DET) | (code == OM_T_ACTIVE_NORM);
      end
      else
      begin
         mode_ok = (code <= OM_I_TYPE1_TAG) | (code == OM_I_SUBC_STREAM)
                 | (code == OM_I_BPSK_STREAM);
      end
   endfunction

   // Bit rate code within fc/128..fc/2
   function automatic logic rate_ok(input logic [3:0] code);
      rate_ok = code <= RATE_FC2;
   endfunction

   wire logic is_peer   = mode_ok(targ, om) & (om == OM_I_ACTIVE_PEER
                        | (targ & om == OM_T_ACTIVE_NORM));
   wire logic is_type_b = ~targ & (om == OM_I_TYPE_B);
   wire logic tx_vhbr   = tx_rate >= RATE_FC8;
   wire logic rx_vhbr   = rx_rate >= RATE_FC8;
   wire logic mode_good = mode_ok(targ, om);
   wire logic rate_good = rate_ok(tx_rate) & rate_ok(rx_rate)
                        & (~tx_vhbr | is_type_b)
                        & (~rx_vhbr | rx_rate == RATE_FC8 | rx_rate == RATE_FC4);
   wire logic txrx_ok   = mode_good & rate_good;

   // Operation control: power-up reset only, set-default leaves it alone
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         operation_control <= RST_OPERATION_CONTROL;
      else if (wr & hit_oc)
         operation_control <= wd & MASK_OPERATION_CONTROL;
      else if (cmd_field_on)
         operation_control[OC_TX_ENABLE] <= 1'b1;
      else if (tx_done_evt & is_peer)
         operation_control[OC_TX_ENABLE] <= 1'b0;
   end

   // Mode register: power-up and set-default
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         mode_definition <= RST_MODE_DEFINITION;
      else if (cmd_set_default)
         mode_definition <= RST_MODE_DEFINITION;
      else if (wr & hit_md)
         mode_definition <= wd & MASK_MODE_DEFINITION;
   end

   // Bit rate register: power-up, set-default, normal NFC command
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         bit_rate_definition <= RST_BIT_RATE_DEFINITION;
      else if (cmd_set_default)
         bit_rate_definition <= RST_BIT_RATE_DEFINITION;
      else if (cmd_normal_nfc)
         bit_rate_definition <= NORMAL_NFC_RATE;
      else if (wr & hit_br)
         bit_rate_definition <= wd;
   end

   // Decoded controls
   rmrc_ctrl_t next_ctrl;
   always_comb
   begin
      next_ctrl = '0;
      next_ctrl.osc_reg_on     = operation_control[OC_READY];
      next_ctrl.rx_allowed     = operation_control[OC_RX_ENABLE] & txrx_ok;
      next_ctrl.tx_allowed     = operation_control[OC_TX_ENABLE] & txrx_ok;
      next_ctrl.am_channel_on  = ~operation_control[OC_ONE_CHANNEL] | ~channel_choice_i;
      next_ctrl.pm_channel_on  = ~operation_control[OC_ONE_CHANNEL] | channel_choice_i;
      next_ctrl.auto_channel   = ~operation_control[OC_ONE_CHANNEL]
                               & ~operation_control[OC_MANUAL_SEL];
      next_ctrl.wakeup_mode_on = operation_control[OC_WAKEUP];
      next_ctrl.target_role    = targ;
      next_ctrl.operation_mode_code = om;
      next_ctrl.transmit_rate_code  = tx_rate;
      next_ctrl.receive_rate_code   = rx_rate;
   end

   // Field-off edge starts response collision avoidance
   wire logic next_coll = mode_definition[MD_AUTO_RESP] & ext_field_off_i
                        & ~field_seen_off;

   // Read mux
   wire logic [7:0] status = {4'h0, mode_good, rate_good, txrx_ok, field_seen_off};
   wire logic [7:0] rd = hit_oc ? operation_control :
                         hit_md ? mode_definition :
                         hit_br ? bit_rate_definition :
                         hit_st ? status : 8'h00;

   // Registered outputs and APB answer (no wait state)
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_o                 <= '0;
         collision_resp_start_o <= 1'b0;
         field_seen_off         <= 1'b0;
         pready_o               <= 1'b0;
         pslverr_o              <= 1'b0;
         prdata_o               <= 32'h0000_0000;
      end
      else
      begin
         ctrl_o                 <= next_ctrl;
         collision_resp_start_o <= next_coll;
         field_seen_off         <= ext_field_off_i;
         pready_o               <= setup;
         pslverr_o              <= setup & ~mapped;
         prdata_o               <= setup & ~pwrite_i ? {24'h00_0000, rd} : 32'h0000_0000;
      end
   end

   // Unsupported configuration keeps transmit and receive off
   a_bad_cfg_blocks: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !$past(txrx_ok) |-> !ctrl_o.tx_allowed && !ctrl_o.rx_allowed)
      else $error("tx or rx allowed with bad configuration");

   a_bad_rate_blocks: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !$past(rate_good) |-> !ctrl_o.rx_allowed)
      else $error("rx allowed with bad rate");

   a_setdef_keeps_oc: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cmd_set_default && !(wr && hit_oc) && !cmd_field_on && !tx_done_evt
      |=> $stable(operation_control))
      else $error("set default changed operation control");

   a_setdef_mode: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cmd_set_default |=> mode_definition == RST_MODE_DEFINITION
                          && bit_rate_definition == RST_BIT_RATE_DEFINITION)
      else $error("set default did not restore mode or rate");

   a_field_on_tx: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cmd_field_on |=> operation_control[OC_TX_ENABLE])
      else $error("field on did not set transmit enable");

   a_rx_gate: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      ctrl_o.rx_allowed |-> $past(operation_control[OC_RX_ENABLE]))
      else $error("receive allowed while disabled");

   a_coll_start: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(ext_field_off_i) && mode_definition[MD_AUTO_RESP] |=> collision_resp_start_o)
      else $error("collision avoidance not started");

   a_normal_nfc_load: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cmd_normal_nfc && !cmd_set_default |=> bit_rate_definition == NORMAL_NFC_RATE)
      else $error("normal nfc did not load bit rate");

   a_unused_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      operation_control[1:0] == 2'b00 && mode_definition[2:1] == 2'b00)
      else $error("unused bits not zero");

   a_ready_power: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      ##1 ctrl_o.osc_reg_on == $past(operation_control[OC_READY]))
      else $error("oscillator enable mismatch");

   a_osc_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !operation_control[OC_READY] |=> !ctrl_o.osc_reg_on)
      else $error("oscillator on while ready bit clear");

   a_rx_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !operation_control[OC_RX_ENABLE] |=> !ctrl_o.rx_allowed)
      else $error("receive allowed with enable clear");

   // Receive channel usage
   a_both_channels: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !operation_control[OC_ONE_CHANNEL] |=> ctrl_o.am_channel_on && ctrl_o.pm_channel_on)
      else $error("a channel is off in two-channel use");

   a_one_channel: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      operation_control[OC_ONE_CHANNEL] |=> ctrl_o.am_channel_on != ctrl_o.pm_channel_on)
      else $error("one-channel use not exclusive");

   a_manual_sel: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      operation_control[OC_MANUAL_SEL] |=> !ctrl_o.auto_channel)
      else $error("automatic choice in manual mode");

   // Transmit enable clear and hold
   a_tx_clear_peer: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      tx_done_evt && is_peer && !(wr && hit_oc) && !cmd_field_on
      |=> !operation_control[OC_TX_ENABLE])
      else $error("transmit enable kept after peer transmission");

   a_tx_keep_other: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      peer_mode_tx_done_i && !is_peer && !(wr && hit_oc) && !cmd_field_on
      |=> $stable(operation_control))
      else $error("transmit enable cleared outside peer mode");

   a_wakeup_follow: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> ctrl_o.wakeup_mode_on == $past(operation_control[OC_WAKEUP]))
      else $error("wake-up output mismatch");

   // Role and mode decoding
   a_role_copy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> ctrl_o.target_role == $past(targ)
               && ctrl_o.operation_mode_code == $past(om))
      else $error("role or mode code output mismatch");

   a_init_map: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !targ && om == 4'h5 |-> !mode_good)
      else $error("unused initiator code accepted");

   a_target_map: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      targ && om > OM_T_ACTIVE_NORM |-> !mode_good)
      else $error("unused target code accepted");

   a_bad_mode_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !mode_good |=> !ctrl_o.tx_allowed && !ctrl_o.rx_allowed)
      else $error("tx or rx allowed with bad mode");

   // Bit rate decoding
   a_tx_rate_copy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> ctrl_o.transmit_rate_code == $past(tx_rate))
      else $error("transmit rate output mismatch");

   a_rx_rate_copy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> ctrl_o.receive_rate_code == $past(rx_rate))
      else $error("receive rate output mismatch");

   a_vhbr_tx: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      tx_vhbr && !is_type_b |=> !ctrl_o.tx_allowed)
      else $error("very high transmit rate outside type B");

   a_vhbr_rx: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rx_rate == RATE_FC2 |=> !ctrl_o.rx_allowed)
      else $error("receive at unsupported very high rate");

   a_unused_rate: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      tx_rate > RATE_FC2 |=> !ctrl_o.tx_allowed && !ctrl_o.rx_allowed)
      else $error("tx or rx allowed with unused rate code");

   // Collision avoidance pulse
   a_coll_pulse: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      collision_resp_start_o |=> !collision_resp_start_o)
      else $error("collision start longer than one cycle");

   a_coll_disabled: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !mode_definition[MD_AUTO_RESP] |=> !collision_resp_start_o)
      else $error("collision start while disabled");

   // Register writes and ignored writes
   a_oc_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr && hit_oc |=> operation_control == ($past(wd) & MASK_OPERATION_CONTROL))
      else $error("operation control write mismatch");

   a_md_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr && hit_md |=> mode_definition == ($past(wd) & MASK_MODE_DEFINITION))
      else $error("mode write mismatch");

   a_br_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr && hit_br |=> bit_rate_definition == $past(wd))
      else $error("bit rate write mismatch");

   a_lane_ignored: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      access && pwrite_i && !pstrb_i[0]
      |=> $stable(mode_definition) && $stable(bit_rate_definition))
      else $error("write without lane zero took effect");

   a_unmapped_ignored: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      access && pwrite_i && !mapped
      |=> $stable(mode_definition) && $stable(bit_rate_definition))
      else $error("unmapped write took effect");

   // Bus answer timing and read data
   a_ready_after_setup: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      setup |=> pready_o)
      else $error("no ready after setup");

   a_err_only_ready: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      pslverr_o |-> pready_o)
      else $error("error flag without ready");

   a_err_unmapped: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      setup && !mapped |=> pslverr_o)
      else $error("unmapped address without error");

   a_rdata_quiet: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside answer cycle");

   a_oc_read: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      setup && !pwrite_i && hit_oc |=> prdata_o[7:0] == $past(operation_control))
      else $error("operation control read mismatch");

   a_md_read: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      setup && !pwrite_i && hit_md |=> prdata_o[7:0] == $past(mode_definition))
      else $error("mode read mismatch");

   a_br_read: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      setup && !pwrite_i && hit_br |=> prdata_o[7:0] == $past(bit_rate_definition))
      else $error("bit rate read mismatch");

   a_events_read_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      setup && !pwrite_i && hit_ce |=> prdata_o == 32'h0000_0000)
      else $error("event register read not zero");

endmodule

`default_nettype wire
